// File: design/diag_cfg_pkg.sv
// Purpose: Constants for the input diagnostics configuration register bank
// Assumes: Eight-bit registers on the device's own register port
// Notes: Offsets, masks, reset values and field positions are defined here; the bench and checks also repeat some of them as literals
package diag_cfg_pkg;

    localparam int NUM_REGS = 4;
    localparam int IDX_W = 2;

    // Register offsets on the control port
    localparam logic [7:0] ADDR_BIAS_OVERVOLT_GUARD_CFG = 8'h51;
    localparam logic [7:0] ADDR_INPUT_FAULT_GUARD_CFG = 8'h52;
    localparam logic [7:0] ADDR_MONITOR_CHANNEL_ENABLE = 8'h53;
    localparam logic [7:0] ADDR_MONITOR_FILTER_CFG = 8'h54;

    // Bank index of each register
    localparam logic [IDX_W-1:0] IDX_BIAS_GUARD = 2'h0;
    localparam logic [IDX_W-1:0] IDX_INPUT_GUARD = 2'h1;
    localparam logic [IDX_W-1:0] IDX_MON_ENABLE = 2'h2;
    localparam logic [IDX_W-1:0] IDX_MON_FILTER = 2'h3;

    // Reset values
    localparam logic [7:0] RST_BIAS_OVERVOLT_GUARD_CFG = 8'h40;
    localparam logic [7:0] RST_INPUT_FAULT_GUARD_CFG = 8'h44;
    localparam logic [7:0] RST_MONITOR_CHANNEL_ENABLE = 8'h00;
    localparam logic [7:0] RST_MONITOR_FILTER_CFG = 8'h48;

    // Writable bits; reserved bits stay zero
    localparam logic [7:0] WMASK_BIAS_OVERVOLT_GUARD_CFG = 8'he0;
    localparam logic [7:0] WMASK_INPUT_FAULT_GUARD_CFG = 8'hfc;
    localparam logic [7:0] WMASK_MONITOR_CHANNEL_ENABLE = 8'hfe;
    localparam logic [7:0] WMASK_MONITOR_FILTER_CFG = 8'h6d;

    // Field positions
    localparam int GUARD_W = 3;
    localparam int FILT_W = 2;
    localparam int MON_W = 4;
    localparam int BIAS_OVERVOLT_GUARD_LSB = 5;
    localparam int INPUT_TO_BIAS_GUARD_LSB = 5;
    localparam int INPUT_OVERVOLT_GUARD_LSB = 2;
    localparam int FORCE_ENABLE_BIT = 7;
    localparam int MANUAL_MON_LSB = 3;
    localparam int ANALOG_SUPPLY_ON_BIT = 2;
    localparam int SPARE_ANALOG_ON_BIT = 1;
    localparam int ANALOG_SUPPLY_FILT_LSB = 5;
    localparam int BATTERY_FILT_LSB = 2;
    localparam int MERGE_FAULT_BIT = 0;

    // Guard band step and filter codes
    localparam logic [7:0] GUARD_STEP_MV = 8'h1e;
    localparam logic [1:0] FILT_3M5HZ = 2'h0;
    localparam logic [1:0] FILT_200KHZ = 2'h1;
    localparam logic [1:0] FILT_100KHZ = 2'h2;
    localparam logic [1:0] FILT_BYPASS = 2'h3;

endpackage

// File: design/input_diag_config_regs.sv
// Purpose: Input diagnostics configuration bank: guard bands, monitor enables, filters, fault merge
// Assumes: Register port, enables and raw faults all come from logic on core_clk
// Notes: Reads answer one cycle after the strobe; unmapped reads return zero
//
// Contract
// - Bias overvoltage lower guard band, bits 7-5, value times 30mV.
// - Input-to-bias upper guard band, bits 7-5, reset 010b, value times 30mV.
// - Input overvoltage lower guard band, bits 4-2, reset 001b, value times 30mV.
// - Force bit clear: four monitors follow any input diagnostic enable; set: manual bits.
// - Bits 6-3 manually enable load, bias, battery, temperature monitors under force.
// - Bit 2 enables analog supply monitor diagnostics; resets to zero.
// - Bit 1 enables spare analog monitor diagnostics; resets to zero.
// - Bits 6-5, reset 10b, choose analog supply filter: 3.5MHz, 200kHz, 100kHz, bypass.
// - Bits 3-2, reset 10b, choose battery filter with the same four choices.
// - Bit 0 set merges input overvoltage into a single battery-short fault.
`timescale 1ns/10ps

module input_diag_config_regs (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rdata_valid,
    input wire logic input_diag_any_on,
    input wire logic input_overvolt_raw,
    input wire logic input_short_batt_raw,
    output logic [2:0] bias_overvolt_guard_band,
    output logic [7:0] bias_overvolt_guard_mv,
    output logic [2:0] input_to_bias_guard_band,
    output logic [7:0] input_to_bias_guard_mv,
    output logic [2:0] input_overvolt_guard_band,
    output logic [7:0] input_overvolt_guard_mv,
    output logic bias_load_monitor_on,
    output logic bias_supply_monitor_on,
    output logic battery_monitor_on,
    output logic temp_monitor_on,
    output logic analog_supply_monitor_on,
    output logic spare_analog_monitor_on,
    output logic [1:0] analog_supply_filter_choice,
    output logic analog_supply_filter_bypass,
    output logic [1:0] battery_filter_choice,
    output logic battery_filter_bypass,
    output logic merge_battery_short_fault,
    output logic input_overvolt_fault,
    output logic battery_short_fault
);

    typedef struct packed {
        logic [3:0][7:0] cfg;
        logic [7:0] rdata;
        logic rvalid;
        logic [7:0] bias_mv;
        logic [7:0] ib_mv;
        logic [7:0] ov_mv;
        logic [3:0] mon_on;
        logic asup_bypass;
        logic batt_bypass;
        logic ov_fault;
        logic bs_fault;
    } state_t;

    localparam logic [3:0][7:0] RESET_VALUES = {
        diag_cfg_pkg::RST_MONITOR_FILTER_CFG,
        diag_cfg_pkg::RST_MONITOR_CHANNEL_ENABLE,
        diag_cfg_pkg::RST_INPUT_FAULT_GUARD_CFG,
        diag_cfg_pkg::RST_BIAS_OVERVOLT_GUARD_CFG
    };
    localparam logic [3:0][7:0] WRITE_MASKS = {
        diag_cfg_pkg::WMASK_MONITOR_FILTER_CFG,
        diag_cfg_pkg::WMASK_MONITOR_CHANNEL_ENABLE,
        diag_cfg_pkg::WMASK_INPUT_FAULT_GUARD_CFG,
        diag_cfg_pkg::WMASK_BIAS_OVERVOLT_GUARD_CFG
    };
    localparam state_t RESET_STATE = '{
        cfg: RESET_VALUES,
        rdata: 8'h00,
        rvalid: 1'b0,
        bias_mv: 8'h3c,
        ib_mv: 8'h3c,
        ov_mv: 8'h1e,
        mon_on: 4'h0,
        asup_bypass: 1'b0,
        batt_bypass: 1'b0,
        ov_fault: 1'b0,
        bs_fault: 1'b0
    };

    state_t st;
    state_t next_st;

    logic addr_hit;
    logic [diag_cfg_pkg::IDX_W-1:0] addr_idx;
    logic [7:0] addr_offset;

    function automatic logic [7:0] guard_to_mv(input logic [2:0] code);
        guard_to_mv = 8'({5'h00, code} * diag_cfg_pkg::GUARD_STEP_MV);
    endfunction

    always_comb begin
        addr_offset = reg_addr - diag_cfg_pkg::ADDR_BIAS_OVERVOLT_GUARD_CFG;
        addr_hit = (reg_addr >= diag_cfg_pkg::ADDR_BIAS_OVERVOLT_GUARD_CFG)
            && (reg_addr <= diag_cfg_pkg::ADDR_MONITOR_FILTER_CFG);
        addr_idx = addr_offset[diag_cfg_pkg::IDX_W-1:0];
    end

    always_comb begin
        logic [2:0] bias_code;
        logic [2:0] ib_code;
        logic [2:0] ov_code;
        logic [7:0] mon_reg;
        logic [7:0] filt_reg;
        bias_code = 3'h0;
        ib_code = 3'h0;
        ov_code = 3'h0;
        mon_reg = 8'h00;
        filt_reg = 8'h00;
        next_st = st;
        next_st.rvalid = 1'b0;
        // Reads return the value held before a same-cycle write
        if (reg_rd) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = addr_hit ? st.cfg[addr_idx] : 8'h00;
        end
        // Reserved bits are masked off and always read zero
        if (reg_wr && addr_hit) begin
            next_st.cfg[addr_idx] = reg_wdata & WRITE_MASKS[addr_idx];
        end
        bias_code = next_st.cfg[diag_cfg_pkg::IDX_BIAS_GUARD][diag_cfg_pkg::BIAS_OVERVOLT_GUARD_LSB +: 3];
        ib_code = next_st.cfg[diag_cfg_pkg::IDX_INPUT_GUARD][diag_cfg_pkg::INPUT_TO_BIAS_GUARD_LSB +: 3];
        ov_code = next_st.cfg[diag_cfg_pkg::IDX_INPUT_GUARD][diag_cfg_pkg::INPUT_OVERVOLT_GUARD_LSB +: 3];
        mon_reg = next_st.cfg[diag_cfg_pkg::IDX_MON_ENABLE];
        filt_reg = next_st.cfg[diag_cfg_pkg::IDX_MON_FILTER];
        next_st.bias_mv = guard_to_mv(bias_code);
        next_st.ib_mv = guard_to_mv(ib_code);
        next_st.ov_mv = guard_to_mv(ov_code);
        // Auto mode ties the four monitors to any input diagnostic
        if (mon_reg[diag_cfg_pkg::FORCE_ENABLE_BIT]) begin
            next_st.mon_on = mon_reg[diag_cfg_pkg::MANUAL_MON_LSB +: diag_cfg_pkg::MON_W];
        end else begin
            next_st.mon_on = {diag_cfg_pkg::MON_W{input_diag_any_on}};
        end
        next_st.asup_bypass = filt_reg[diag_cfg_pkg::ANALOG_SUPPLY_FILT_LSB +: 2] == diag_cfg_pkg::FILT_BYPASS;
        next_st.batt_bypass = filt_reg[diag_cfg_pkg::BATTERY_FILT_LSB +: 2] == diag_cfg_pkg::FILT_BYPASS;
        if (filt_reg[diag_cfg_pkg::MERGE_FAULT_BIT]) begin
            next_st.ov_fault = 1'b0;
            next_st.bs_fault = input_overvolt_raw | input_short_batt_raw;
        end else begin
            next_st.ov_fault = input_overvolt_raw;
            next_st.bs_fault = input_short_batt_raw;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            st <= RESET_STATE;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign reg_rdata_valid = st.rvalid;
    assign bias_overvolt_guard_band =
        st.cfg[diag_cfg_pkg::IDX_BIAS_GUARD][diag_cfg_pkg::BIAS_OVERVOLT_GUARD_LSB +: 3];
    assign bias_overvolt_guard_mv = st.bias_mv;
    assign input_to_bias_guard_band =
        st.cfg[diag_cfg_pkg::IDX_INPUT_GUARD][diag_cfg_pkg::INPUT_TO_BIAS_GUARD_LSB +: 3];
    assign input_to_bias_guard_mv = st.ib_mv;
    assign input_overvolt_guard_band =
        st.cfg[diag_cfg_pkg::IDX_INPUT_GUARD][diag_cfg_pkg::INPUT_OVERVOLT_GUARD_LSB +: 3];
    assign input_overvolt_guard_mv = st.ov_mv;
    assign bias_load_monitor_on = st.mon_on[3];
    assign bias_supply_monitor_on = st.mon_on[2];
    assign battery_monitor_on = st.mon_on[1];
    assign temp_monitor_on = st.mon_on[0];
    assign analog_supply_monitor_on =
        st.cfg[diag_cfg_pkg::IDX_MON_ENABLE][diag_cfg_pkg::ANALOG_SUPPLY_ON_BIT];
    assign spare_analog_monitor_on =
        st.cfg[diag_cfg_pkg::IDX_MON_ENABLE][diag_cfg_pkg::SPARE_ANALOG_ON_BIT];
    assign analog_supply_filter_choice =
        st.cfg[diag_cfg_pkg::IDX_MON_FILTER][diag_cfg_pkg::ANALOG_SUPPLY_FILT_LSB +: 2];
    assign analog_supply_filter_bypass = st.asup_bypass;
    assign battery_filter_choice = st.cfg[diag_cfg_pkg::IDX_MON_FILTER][diag_cfg_pkg::BATTERY_FILT_LSB +: 2];
    assign battery_filter_bypass = st.batt_bypass;
    assign merge_battery_short_fault = st.cfg[diag_cfg_pkg::IDX_MON_FILTER][diag_cfg_pkg::MERGE_FAULT_BIT];
    assign input_overvolt_fault = st.ov_fault;
    assign battery_short_fault = st.bs_fault;

    // Checks
    logic wr_bias;
    logic wr_input;
    logic wr_mon;
    logic wr_filt;
    assign wr_bias = ce && reg_wr && reg_addr == diag_cfg_pkg::ADDR_BIAS_OVERVOLT_GUARD_CFG;
    assign wr_input = ce && reg_wr && reg_addr == diag_cfg_pkg::ADDR_INPUT_FAULT_GUARD_CFG;
    assign wr_mon = ce && reg_wr && reg_addr == diag_cfg_pkg::ADDR_MONITOR_CHANNEL_ENABLE;
    assign wr_filt = ce && reg_wr && reg_addr == diag_cfg_pkg::ADDR_MONITOR_FILTER_CFG;

    sequence s_reset_release;
        !resetn ##1 resetn;
    endsequence

    sequence s_merged_overvolt;
        ce && merge_battery_short_fault && !wr_filt && input_overvolt_raw;
    endsequence

    // Write, one idle cycle, then a read of the same register
    sequence s_write_then_read(logic wr_ev, logic [7:0] addr);
        wr_ev ##1 (ce && !reg_wr) ##1 (ce && reg_rd && !reg_wr && reg_addr == addr);
    endsequence

    property p_bias_guard;
        @(posedge core_clk) disable iff (!resetn)
        wr_bias |=> bias_overvolt_guard_mv == 8'(30 * $past(reg_wdata[7:5]))
            && bias_overvolt_guard_band == $past(reg_wdata[7:5]);
    endproperty
    a_bias_guard: assert property (p_bias_guard) else $error("bias guard band wrong");

    property p_ib_guard_reset;
        @(posedge core_clk)
        s_reset_release |-> input_to_bias_guard_band == 3'h2 && input_to_bias_guard_mv == 8'h3c;
    endproperty
    a_ib_guard_reset: assert property (p_ib_guard_reset) else $error("input-to-bias guard reset wrong");

    property p_ov_guard;
        @(posedge core_clk) disable iff (!resetn)
        wr_input |=> input_overvolt_guard_mv == 8'(30 * $past(reg_wdata[4:2]))
            && input_to_bias_guard_mv == 8'(30 * $past(reg_wdata[7:5]));
    endproperty
    a_ov_guard: assert property (p_ov_guard) else $error("input overvoltage guard band wrong");

    property p_auto_monitors;
        @(posedge core_clk) disable iff (!resetn)
        ce && !wr_mon && !st.cfg[diag_cfg_pkg::IDX_MON_ENABLE][7]
            |=> {bias_load_monitor_on, bias_supply_monitor_on, battery_monitor_on, temp_monitor_on}
                == {4{$past(input_diag_any_on)}};
    endproperty
    a_auto_monitors: assert property (p_auto_monitors) else $error("auto monitor enable wrong");

    property p_manual_monitors;
        @(posedge core_clk) disable iff (!resetn)
        wr_mon && reg_wdata[7] |=>
            {bias_load_monitor_on, bias_supply_monitor_on, battery_monitor_on, temp_monitor_on}
                == $past(reg_wdata[6:3]);
    endproperty
    a_manual_monitors: assert property (p_manual_monitors) else $error("manual monitor enable wrong");

    property p_supply_enable;
        @(posedge core_clk) disable iff (!resetn)
        wr_mon |=> analog_supply_monitor_on == $past(reg_wdata[2]);
    endproperty
    a_supply_enable: assert property (p_supply_enable) else $error("analog supply enable wrong");

    property p_spare_enable;
        @(posedge core_clk) disable iff (!resetn)
        wr_mon |=> spare_analog_monitor_on == $past(reg_wdata[1]);
    endproperty
    a_spare_enable: assert property (p_spare_enable) else $error("spare analog enable wrong");

    property p_supply_filter;
        @(posedge core_clk) disable iff (!resetn)
        wr_filt |=> analog_supply_filter_choice == $past(reg_wdata[6:5])
            && analog_supply_filter_bypass == ($past(reg_wdata[6:5]) == 2'h3);
    endproperty
    a_supply_filter: assert property (p_supply_filter) else $error("analog supply filter wrong");

    property p_battery_filter_reset;
        @(posedge core_clk)
        s_reset_release |-> battery_filter_choice == 2'h2 && analog_supply_filter_choice == 2'h2
            && !battery_filter_bypass;
    endproperty
    a_battery_filter_reset: assert property (p_battery_filter_reset) else $error("filter reset wrong");

    property p_merge_fault;
        @(posedge core_clk) disable iff (!resetn)
        s_merged_overvolt |=> battery_short_fault && !input_overvolt_fault;
    endproperty
    a_merge_fault: assert property (p_merge_fault) else $error("merged battery short fault wrong");

    property p_reserved_zero;
        @(posedge core_clk) disable iff (!resetn)
        s_write_then_read(wr_bias, diag_cfg_pkg::ADDR_BIAS_OVERVOLT_GUARD_CFG)
            |=> reg_rdata_valid && reg_rdata[4:0] == 5'h00 && reg_rdata[7:5] == $past(reg_wdata[7:5], 3);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

    property p_reserved_read;
        @(posedge core_clk) disable iff (!resetn)
        ce && reg_rd && addr_hit
            |=> reg_rdata_valid && (reg_rdata & ~WRITE_MASKS[$past(addr_idx)]) == 8'h00;
    endproperty
    a_reserved_read: assert property (p_reserved_read) else $error("reserved bits read back nonzero");

    property p_merge_split;
        @(posedge core_clk) disable iff (!resetn)
        ce && !merge_battery_short_fault && !wr_filt
            |=> input_overvolt_fault == $past(input_overvolt_raw)
                && battery_short_fault == $past(input_short_batt_raw);
    endproperty
    a_merge_split: assert property (p_merge_split) else $error("separate fault reporting wrong");

    property p_enables_reset;
        @(posedge core_clk)
        s_reset_release |-> !analog_supply_monitor_on && !spare_analog_monitor_on && !bias_load_monitor_on
            && !bias_supply_monitor_on && !battery_monitor_on && !temp_monitor_on;
    endproperty
    a_enables_reset: assert property (p_enables_reset) else $error("monitor enables not cleared by reset");

endmodule

// File: tb/tb_input_diag_config_regs.sv
// Purpose: Self-checking bench for the input diagnostics configuration bank
// Assumes: Inputs change at the falling edge; read data is compared in a separate watcher process
// Notes: A shadow copy of the four registers holds the expected register values; fault and auto monitor checks also use the driven inputs
`timescale 1ns/10ps

module tb_input_diag_config_regs;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic input_diag_any_on = 1'b0;
    logic input_overvolt_raw = 1'b0;
    logic input_short_batt_raw = 1'b0;
    logic [7:0] reg_rdata, bias_overvolt_guard_mv, input_to_bias_guard_mv, input_overvolt_guard_mv;
    logic [2:0] bias_overvolt_guard_band, input_to_bias_guard_band, input_overvolt_guard_band;
    logic [1:0] analog_supply_filter_choice, battery_filter_choice;
    logic reg_rdata_valid, bias_load_monitor_on, bias_supply_monitor_on, battery_monitor_on, temp_monitor_on;
    logic analog_supply_monitor_on, spare_analog_monitor_on, analog_supply_filter_bypass, battery_filter_bypass;
    logic merge_battery_short_fault, input_overvolt_fault, battery_short_fault;
    int n_fail = 0;
    int total_checks = 0;
    logic [7:0] exp_q[$];
    logic [7:0] shadow [0:3];

    input_diag_config_regs i_dut (
        .core_clk(core_clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
        .input_diag_any_on(input_diag_any_on), .input_overvolt_raw(input_overvolt_raw),
        .input_short_batt_raw(input_short_batt_raw), .bias_overvolt_guard_band(bias_overvolt_guard_band),
        .bias_overvolt_guard_mv(bias_overvolt_guard_mv), .input_to_bias_guard_band(input_to_bias_guard_band),
        .input_to_bias_guard_mv(input_to_bias_guard_mv), .input_overvolt_guard_band(input_overvolt_guard_band),
        .input_overvolt_guard_mv(input_overvolt_guard_mv), .bias_load_monitor_on(bias_load_monitor_on),
        .bias_supply_monitor_on(bias_supply_monitor_on), .battery_monitor_on(battery_monitor_on),
        .temp_monitor_on(temp_monitor_on), .analog_supply_monitor_on(analog_supply_monitor_on),
        .spare_analog_monitor_on(spare_analog_monitor_on), .analog_supply_filter_choice(analog_supply_filter_choice),
        .analog_supply_filter_bypass(analog_supply_filter_bypass), .battery_filter_choice(battery_filter_choice),
        .battery_filter_bypass(battery_filter_bypass), .merge_battery_short_fault(merge_battery_short_fault),
        .input_overvolt_fault(input_overvolt_fault), .battery_short_fault(battery_short_fault)
    );

    always #12.5 core_clk = ~core_clk;

    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task summarize;
        if (n_fail == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task load_reset;
        shadow[0] = diag_cfg_pkg::RST_BIAS_OVERVOLT_GUARD_CFG;
        shadow[1] = diag_cfg_pkg::RST_INPUT_FAULT_GUARD_CFG;
        shadow[2] = diag_cfg_pkg::RST_MONITOR_CHANNEL_ENABLE;
        shadow[3] = diag_cfg_pkg::RST_MONITOR_FILTER_CFG;
    endtask

    function automatic logic [7:0] mask_of(input logic [7:0] a);
        case (a)
            diag_cfg_pkg::ADDR_BIAS_OVERVOLT_GUARD_CFG: return diag_cfg_pkg::WMASK_BIAS_OVERVOLT_GUARD_CFG;
            diag_cfg_pkg::ADDR_INPUT_FAULT_GUARD_CFG: return diag_cfg_pkg::WMASK_INPUT_FAULT_GUARD_CFG;
            diag_cfg_pkg::ADDR_MONITOR_CHANNEL_ENABLE: return diag_cfg_pkg::WMASK_MONITOR_CHANNEL_ENABLE;
            diag_cfg_pkg::ADDR_MONITOR_FILTER_CFG: return diag_cfg_pkg::WMASK_MONITOR_FILTER_CFG;
            default: return 8'h00;
        endcase
    endfunction

    // One strobe cycle; the read note is taken before the write lands, so a joint access expects old data
    task xfer(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        logic hit;
        hit = (a >= 8'h51) && (a <= 8'h54);
        @(negedge core_clk);
        reg_wr = w;
        reg_rd = r;
        reg_addr = a;
        reg_wdata = d;
        if (r) exp_q.push_back(hit ? shadow[a[1:0] - 2'd1] : 8'h00);
        if (w && hit && ce) shadow[a[1:0] - 2'd1] = d & mask_of(a);
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    endtask

    task check_fields;
        logic [7:0] b, g, m, f;
        logic [3:0] mon;
        b = shadow[0];
        g = shadow[1];
        m = shadow[2];
        f = shadow[3];
        mon = m[7] ? m[6:3] : {4{input_diag_any_on}};
        check("bias_band", {5'h00, bias_overvolt_guard_band}, {5'h00, b[7:5]});
        check("bias_mv", bias_overvolt_guard_mv, 8'(b[7:5]) * 8'h1e);
        check("in_bias_band", {5'h00, input_to_bias_guard_band}, {5'h00, g[7:5]});
        check("in_bias_mv", input_to_bias_guard_mv, 8'(g[7:5]) * 8'h1e);
        check("in_ov_band", {5'h00, input_overvolt_guard_band}, {5'h00, g[4:2]});
        check("in_ov_mv", input_overvolt_guard_mv, 8'(g[4:2]) * 8'h1e);
        check("monitors", {4'h0, bias_load_monitor_on, bias_supply_monitor_on, battery_monitor_on,
            temp_monitor_on}, {4'h0, mon});
        check("filters", {4'h0, analog_supply_filter_choice, battery_filter_choice}, {4'h0, f[6:5], f[3:2]});
        check("flags", {analog_supply_monitor_on, spare_analog_monitor_on, analog_supply_filter_bypass,
            battery_filter_bypass, merge_battery_short_fault, input_overvolt_fault, battery_short_fault, 1'b0},
            {m[2], m[1], &f[6:5], &f[3:2], f[0], ~f[0] & input_overvolt_raw,
            input_short_batt_raw | (f[0] & input_overvolt_raw), 1'b0});
    endtask

    task set_in(input logic any, input logic ov, input logic sh);
        @(negedge core_clk);
        input_diag_any_on = any;
        input_overvolt_raw = ov;
        input_short_batt_raw = sh;
        @(negedge core_clk);
        check_fields;
    endtask

    // Read answers are matched in order of request
    always @(negedge core_clk) begin
        if (resetn === 1'b1 && reg_rdata_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_fail++;
                $display("CHECK FAILED read_count expected none seen %h", reg_rdata);
            end else begin
                check("reg_rdata", reg_rdata, exp_q.pop_front());
            end
        end
    end

    initial begin
        repeat (40000) @(posedge core_clk);
        n_fail++;
        $display("CHECK FAILED watchdog expected finish seen hang");
        summarize;
    end

    initial begin
        logic [7:0] d;
        void'($urandom(7354));
        load_reset;
        repeat (6) @(negedge core_clk);
        resetn = 1'b1;
        check_fields;
        for (int a = 8'h50; a <= 8'h55; a++) xfer(1'b0, 1'b1, 8'(a), 8'h00);
        for (int a = 8'h51; a <= 8'h54; a++) begin
            xfer(1'b1, 1'b0, 8'(a), 8'hff);
            xfer(1'b0, 1'b1, 8'(a), 8'h00);
        end
        for (int v = 0; v < 8; v++) begin
            xfer(1'b1, 1'b0, 8'h51, {3'(v), 5'h1f});
            xfer(1'b1, 1'b0, 8'h52, {3'(v), 3'(7 - v), 2'h3});
            check_fields;
        end
        for (int v = 0; v < 4; v++) begin
            d = 8'($urandom);
            d[6:5] = 2'(v);
            d[3:2] = 2'(3 - v);
            d[0] = v[0];
            xfer(1'b1, 1'b1, 8'h54, d);
            for (int c = 0; c < 4; c++) set_in(1'b0, c[1], c[0]);
        end
        for (int i = 0; i < 24; i++) begin
            xfer(1'b1, 1'b1, 8'h53, 8'($urandom));
            set_in(1'($urandom), 1'($urandom), 1'($urandom));
        end
        @(negedge core_clk);
        ce = 1'b0;
        xfer(1'b1, 1'b0, 8'h51, ~shadow[0]);
        @(negedge core_clk);
        ce = 1'b1;
        xfer(1'b0, 1'b1, 8'h51, 8'h00);
        check_fields;
        @(negedge core_clk);
        resetn = 1'b0;
        load_reset;
        @(negedge core_clk);
        resetn = 1'b1;
        set_in(1'b0, 1'b1, 1'b0);
        xfer(1'b0, 1'b1, 8'h54, 8'h00);
        for (int i = 0; i < 10 && exp_q.size() > 0; i++) @(negedge core_clk);
        if (exp_q.size() > 0) begin
            n_fail++;
            $display("CHECK FAILED pending_reads expected 0 seen %0d", exp_q.size());
        end
        summarize;
    end
endmodule
